// >>> verilog/irq_router_pkg.sv
// package for the receiver interrupt enable, source select and pin router
// assumes an 8-bit register port with byte addresses and one system clock
package irq_router_pkg;

  // register addresses on the register port
  localparam logic [7:0] event_enable_mask_addr = 8'h3f;
  localparam logic [7:0] output_pin_select_addr = 8'h40;
  localparam logic [7:0] irq_source_select_addr = 8'h41;
  localparam logic [7:0] flag_status_addr       = 8'h43;
  localparam logic [7:0] flag_clear_addr        = 8'h42;

  // reset values
  localparam logic [7:0] event_enable_mask_rst = 8'h00;
  localparam logic [7:0] output_pin_select_rst = 8'h00;
  localparam logic [7:0] irq_source_select_rst = 8'h00;

  // event bit positions, shared by enable, flag and clear registers
  localparam int sleep_timeout_bit   = 7;
  localparam int receive_timeout_bit = 6;
  localparam int signal_valid_bit    = 5;
  localparam int preamble_found_bit  = 4;
  localparam int syncword_found_bit  = 3;
  localparam int node_match_bit      = 2;
  localparam int check_pass_bit      = 1;
  localparam int packet_finished_bit = 0;

  // pin select field positions (low bit of each 2-bit field)
  localparam int pin_four_select_lsb  = 6;
  localparam int pin_three_select_lsb = 4;
  localparam int pin_two_select_lsb   = 2;
  localparam int pin_one_select_lsb   = 0;

  // source code field positions
  localparam int line_two_source_lsb = 4;
  localparam int line_one_source_lsb = 0;

  // data modes of the data handler
  typedef enum logic [1:0]
  {
    mode_direct = 2'h0,
    mode_buffer = 2'h1,
    mode_packet = 2'h3
  } data_mode_e;

  // raw event inputs from the receiver core
  typedef struct packed
  {
    logic sleep_timeout_event;
    logic receive_timeout_event;
    logic signal_valid_event;
    logic preamble_found_event;
    logic syncword_found_event;
    logic node_match_event;
    logic check_pass_event;
    logic packet_finished_event;
  } rx_events_s;

  // fifo and live status inputs, levels except the byte strobe
  typedef struct packed
  {
    logic queue_not_empty;
    logic queue_threshold_hit;
    logic queue_full;
    logic queue_byte_strobe;
    logic queue_overflow_event;
    logic signal_level_indicator;
  } queue_status_s;

endpackage : irq_router_pkg

// >>> verilog/rx_interrupt_gpo_router.sv
// enable, flag latching, interrupt source selection and output pin routing
// assumes a simple synchronous register port and events one clock wide
`timescale 1ns/1ps

module rx_interrupt_gpo_router
(
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  input  wire irq_router_pkg::data_mode_e    data_mode,
  input  wire irq_router_pkg::rx_events_s    events,
  input  wire irq_router_pkg::queue_status_s queue_status,
  input  wire logic                          demod_data,
  input  wire logic                          recovered_bit_clock,
  input  wire logic                          system_clock_output,
  input  wire logic                          reset_out_low,
  output logic                               irq_line_one,
  output logic                               irq_line_two,
  output logic                               output_pin_one,
  output logic                               output_pin_two,
  output logic                               output_pin_three,
  output logic                               output_pin_four
);

  // software registers
  logic [7:0] event_enable_mask_reg;   // per-event enable
  logic [7:0] output_pin_select_reg;   // pin routing fields
  logic [7:0] irq_source_select_reg;   // line source codes
  logic [7:0] flag_reg;                // latched event flags
  logic [7:0] flag_next;
  logic [7:0] rdata_next;

  // decoded strobes
  wire        wr_enable = reg_write &&
    reg_addr == irq_router_pkg::event_enable_mask_addr;
  wire        wr_pins   = reg_write &&
    reg_addr == irq_router_pkg::output_pin_select_addr;
  wire        wr_source = reg_write &&
    reg_addr == irq_router_pkg::irq_source_select_addr;
  wire        wr_clear  = reg_write &&
    reg_addr == irq_router_pkg::flag_clear_addr;
  wire [7:0]  event_vec = events;
  wire [7:0]  clear_vec = wr_clear ? reg_wdata : 8'h00;

  // gated events; a set beats a clear in the same cycle
  assign flag_next = (flag_reg & ~clear_vec)
                   | (event_vec & event_enable_mask_reg);

  // register writes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      event_enable_mask_reg <= irq_router_pkg::event_enable_mask_rst;
      output_pin_select_reg <= irq_router_pkg::output_pin_select_rst;
      irq_source_select_reg <= irq_router_pkg::irq_source_select_rst;
    end
    else
    begin
      if (wr_enable)
        event_enable_mask_reg <= reg_wdata;
      if (wr_pins)
        output_pin_select_reg <= reg_wdata;
      if (wr_source)
        irq_source_select_reg <= reg_wdata;
    end
  end

  // flag latch: each bit held until a one is written to its clear
  always_ff @(posedge clock)
  begin
    if (rst)
      flag_reg <= 8'h00;
    else
      flag_reg <= flag_next;
  end

  // read mux, clear register reads zero, unmapped reads zero
  // the byte strobe has no place in the flag register
  always_comb
  begin
    case (reg_addr)
      irq_router_pkg::event_enable_mask_addr: rdata_next = event_enable_mask_reg;
      irq_router_pkg::output_pin_select_addr: rdata_next = output_pin_select_reg;
      irq_router_pkg::irq_source_select_addr: rdata_next = irq_source_select_reg;
      irq_router_pkg::flag_status_addr:       rdata_next = flag_reg;
      default:                                rdata_next = 8'h00;
    endcase
  end

  // read data registered on the read strobe
  always_ff @(posedge clock)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= rdata_next;
  end

  // source selection shared by both lines
  function automatic logic pick_source
  (
    input logic [3:0]                    code,
    input irq_router_pkg::data_mode_e    mode,
    input logic [7:0]                    flg,
    input irq_router_pkg::queue_status_s q
  );
    logic r;
    r = 1'b0;
    case (code)
      4'h0: r = 1'b0;
      4'h1: r = flg[irq_router_pkg::signal_valid_bit];
      4'h2: r = flg[irq_router_pkg::preamble_found_bit];
      4'h3: r = flg[irq_router_pkg::syncword_found_bit];
      4'hf: r = 1'b0;
      default:
      begin
        case (mode)
          irq_router_pkg::mode_packet:
          begin
            case (code)
              4'h4: r = flg[irq_router_pkg::node_match_bit];
              4'h5: r = flg[irq_router_pkg::check_pass_bit];
              4'h6: r = flg[irq_router_pkg::packet_finished_bit];
              4'h7: r = flg[irq_router_pkg::sleep_timeout_bit];
              4'h8: r = flg[irq_router_pkg::receive_timeout_bit];
              4'h9: r = q.queue_not_empty;
              4'ha: r = q.queue_threshold_hit;
              4'hb: r = q.queue_full;
              4'hc: r = q.queue_byte_strobe;
              4'hd: r = q.queue_overflow_event;
              4'he: r = q.signal_level_indicator;
              default: r = 1'b0;
            endcase
          end
          irq_router_pkg::mode_buffer:
          begin
            case (code)
              4'h4: r = flg[irq_router_pkg::sleep_timeout_bit];
              4'h5: r = flg[irq_router_pkg::receive_timeout_bit];
              4'h6: r = q.queue_not_empty;
              4'h7: r = q.queue_threshold_hit;
              4'h8: r = q.queue_full;
              4'h9: r = q.queue_byte_strobe;
              4'ha: r = q.queue_overflow_event;
              4'hb: r = q.signal_level_indicator;
              default: r = 1'b0;
            endcase
          end
          default:
          begin
            case (code)
              4'h4: r = flg[irq_router_pkg::sleep_timeout_bit];
              4'h5: r = flg[irq_router_pkg::receive_timeout_bit];
              4'h6: r = q.signal_level_indicator;
              default: r = 1'b0;
            endcase
          end
        endcase
      end
    endcase
    return r;
  endfunction : pick_source

  // code fields
  wire [3:0] line_two_source_code =
    irq_source_select_reg[irq_router_pkg::line_two_source_lsb +: 4];
  wire [3:0] line_one_source_code =
    irq_source_select_reg[irq_router_pkg::line_one_source_lsb +: 4];
  wire [1:0] pin_four_select  =
    output_pin_select_reg[irq_router_pkg::pin_four_select_lsb +: 2];
  wire [1:0] pin_three_select =
    output_pin_select_reg[irq_router_pkg::pin_three_select_lsb +: 2];
  wire [1:0] pin_two_select   =
    output_pin_select_reg[irq_router_pkg::pin_two_select_lsb +: 2];
  wire [1:0] pin_one_select   =
    output_pin_select_reg[irq_router_pkg::pin_one_select_lsb +: 2];

  // interrupt lines, combinational from latched flags and live queue status
  assign irq_line_two = pick_source(line_two_source_code, data_mode,
                                    flag_reg, queue_status);
  assign irq_line_one = pick_source(line_one_source_code, data_mode,
                                    flag_reg, queue_status);

  // pin multiplexers
  assign output_pin_four  = pin_four_select == 2'h0 ? demod_data :
                            pin_four_select == 2'h1 ? irq_line_one :
                            pin_four_select == 2'h2 ? irq_line_two :
                                                      recovered_bit_clock;
  assign output_pin_three = pin_three_select == 2'h0 ? system_clock_output :
                            pin_three_select == 2'h1 ? irq_line_one :
                            pin_three_select == 2'h2 ? irq_line_two :
                                                       recovered_bit_clock;
  assign output_pin_two   = pin_two_select == 2'h0 ? irq_line_one :
                            pin_two_select == 2'h1 ? irq_line_two :
                            pin_two_select == 2'h2 ? recovered_bit_clock :
                                                     1'b0;
  assign output_pin_one   = pin_one_select == 2'h0 ? reset_out_low :
                            pin_one_select == 2'h1 ? irq_line_one :
                            pin_one_select == 2'h2 ? irq_line_two :
                                                     demod_data;

  // flag holds until cleared
  flag_hold_a: assert property (@(posedge clock) disable iff (rst)
    $past(flag_reg[7]) && !$past(clear_vec[7]) |-> flag_reg[7])
    else $error("sleep flag dropped without clear");

  // disabled event never sets
  disabled_set_a: assert property (@(posedge clock) disable iff (rst)
    !$past(flag_reg[0]) && !$past(event_enable_mask_reg[0]) |-> !flag_reg[0])
    else $error("disabled event set flag");

  // clear with no event drops flag
  clear_drop_a: assert property (@(posedge clock) disable iff (rst)
    clear_vec[5] && !event_vec[5] |=> !flag_reg[5])
    else $error("clear did not drop flag");

  // enabled event sets flag
  enabled_set_a: assert property (@(posedge clock) disable iff (rst)
    event_vec[5] && event_enable_mask_reg[5] |=> flag_reg[5])
    else $error("enabled event missed");

  // pin two constant zero
  pin_two_zero_a: assert property (@(posedge clock) disable iff (rst)
    pin_two_select == 2'h3 |-> !output_pin_two)
    else $error("pin two not zero");

  // code fifteen is quiet
  code_quiet_a: assert property (@(posedge clock) disable iff (rst)
    line_one_source_code == 4'hf |-> !irq_line_one)
    else $error("code fifteen active");

  // lines match on equal codes
  line_match_a: assert property (@(posedge clock) disable iff (rst)
    line_one_source_code == line_two_source_code |->
      irq_line_one == irq_line_two)
    else $error("line mapping differs");

  // enable register updates from write
  enable_write_a: assert property (@(posedge clock) disable iff (rst)
    wr_enable |=> event_enable_mask_reg == $past(reg_wdata))
    else $error("enable write lost");

endmodule : rx_interrupt_gpo_router

// >>> test/mcu_model.sv
// partner model: microcontroller driving the register port
// assumes the block takes strobes on the rising edge of clock
`timescale 1ns/1ps
module mcu_model
(
  input  wire logic       clock,
  output logic            reg_write,
  output logic            reg_read,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // idle port at time zero
  initial
  begin
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // one write, held through the taking edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d; // released data carries no stale value
  endtask : write_reg
  // one read, registered data lands at the taking edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : read_reg
endmodule : mcu_model

// >>> test/tb.sv
// self-checking bench for the interrupt router and pin muxes
// assumes mcu_model as register master and one 25 MHz clock
`timescale 1ns/1ps
module tb;
  logic       clock, rst, demod_data, recovered_bit_clock;
  logic       system_clock_output, reset_out_low;
  logic       reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, bitv;
  logic       irq_line_one, irq_line_two;
  logic       output_pin_one, output_pin_two;
  logic       output_pin_three, output_pin_four;
  logic [3:0] v, e, w;
  logic [1:0] s;
  int         miscompares, check_count, cycles;
  irq_router_pkg::data_mode_e    data_mode;
  irq_router_pkg::rx_events_s    events;
  irq_router_pkg::queue_status_s queue_status;

  rx_interrupt_gpo_router rx_interrupt_gpo_router_inst
  (
    .clock(clock), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .data_mode(data_mode), .events(events), .queue_status(queue_status),
    .demod_data(demod_data), .recovered_bit_clock(recovered_bit_clock),
    .system_clock_output(system_clock_output),
    .reset_out_low(reset_out_low), .irq_line_one(irq_line_one),
    .irq_line_two(irq_line_two), .output_pin_one(output_pin_one),
    .output_pin_two(output_pin_two), .output_pin_three(output_pin_three),
    .output_pin_four(output_pin_four)
  );
  mcu_model mcu_model_inst
  (
    .clock(clock), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  // 40 ns clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic end_sim;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      $display("unexpected at %0t: timeout", $time);
      end_sim();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mcu_model_inst.write_reg(a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    mcu_model_inst.read_reg(a, rd);
    check(rd, x, "read");
  endtask : rchk

  // expected line level: nibble table of source index, 14 is zero
  function automatic logic line_exp(input logic [1:0] m, input logic [3:0] c,
                                    input logic [7:0] f, input logic [5:0] q);
    logic [63:0] t;
    logic [14:0] z;
    z = {1'b0, f, q};
    t = (m == 2'h3) ? 64'he012_345c_d678_9abe :
        (m == 2'h1) ? 64'heeee_0123_45cd_9abe : 64'heeee_eeee_e0cd_9abe;
    return z[t[c*4 +: 4]];
  endfunction : line_exp

  // all modes and codes, line two code c and line one code ~c
  task automatic sweep(input logic [7:0] f, input logic [5:0] q);
    logic [1:0] m;
    logic [3:0] c;
    for (int k = 0; k < 48; k++)
    begin
      m = (k < 16) ? 2'h0 : (k < 32) ? 2'h1 : 2'h3;
      c = k[3:0];
      data_mode <= irq_router_pkg::data_mode_e'(m);
      wr(irq_router_pkg::irq_source_select_addr, {c, ~c});
      @(posedge clock);
      #1;
      check({7'h0, irq_line_two}, {7'h0, line_exp(m, c, f, q)}, "two");
      check({7'h0, irq_line_one}, {7'h0, line_exp(m, ~c, f, q)}, "one");
    end
  endtask : sweep

  initial
  begin
    {rst, demod_data, recovered_bit_clock} = 3'b100;
    {system_clock_output, reset_out_low} = 2'b00;
    data_mode = irq_router_pkg::mode_direct;
    events = '0;
    queue_status = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // reset values, unmapped and read-only places
    rchk(irq_router_pkg::event_enable_mask_addr, 8'h00);
    rchk(irq_router_pkg::output_pin_select_addr, 8'h00);
    rchk(irq_router_pkg::irq_source_select_addr, 8'h00);
    wr(irq_router_pkg::flag_status_addr, 8'hff);
    rchk(irq_router_pkg::flag_status_addr, 8'h00);
    rchk(8'h50, 8'h00);
    $display("test reset done");
    // one enable at a time, all events pulsed
    for (int i = 0; i < 8; i++)
    begin
      bitv = 8'h01 << i;
      wr(irq_router_pkg::event_enable_mask_addr, bitv);
      rchk(irq_router_pkg::event_enable_mask_addr, bitv);
      events <= 8'hff;
      @(posedge clock);
      events <= 8'h00;
      rchk(irq_router_pkg::flag_status_addr, bitv);
      wr(irq_router_pkg::flag_clear_addr, ~bitv);
      rchk(irq_router_pkg::flag_status_addr, bitv);
      wr(irq_router_pkg::flag_clear_addr, bitv);
      rchk(irq_router_pkg::flag_status_addr, 8'h00);
    end
    $display("test enables done");
    // routing of each latched flag and each live status input
    wr(irq_router_pkg::event_enable_mask_addr, 8'hff);
    for (int j = 0; j < 8; j++)
    begin
      events <= 8'h01 << j;
      @(posedge clock);
      events <= 8'h00;
      sweep(8'h01 << j, 6'h00);
      wr(irq_router_pkg::flag_clear_addr, 8'hff);
    end
    for (int j = 0; j < 6; j++)
    begin
      queue_status <= 6'h01 << j;
      sweep(8'h00, 6'h01 << j);
      rchk(irq_router_pkg::flag_status_addr, 8'h00);
    end
    $display("test routing done");
    // pin muxes, lines from live indicator and not-empty in buffer mode
    data_mode <= irq_router_pkg::mode_buffer;
    wr(irq_router_pkg::irq_source_select_addr, 8'h6b);
    for (int n = 0; n < 64; n++)
    begin
      v = n[3:0];
      s = n[5:4];
      {demod_data, recovered_bit_clock} <= {v[0], v[3]};
      {system_clock_output, reset_out_low} <= {v[0], ~v[1]};
      queue_status <= {v[2], 4'h0, v[1]};
      wr(irq_router_pkg::output_pin_select_addr, {s, s + 2'd1, s + 2'd2, ~s});
      @(posedge clock);
      #1;
      e[3] = v[s];
      e[2] = v[s + 2'd1];
      w = {1'b0, v[3], v[2], v[1]};
      e[1] = w[s + 2'd2];
      w = {v[0], v[2], v[1], ~v[1]};
      e[0] = w[~s];
      check({4'h0, output_pin_four, output_pin_three, output_pin_two,
             output_pin_one}, {4'h0, e}, "pins");
    end
    $display("test pins done");
    end_sim();
  end
endmodule : tb
